// file: hw/acst_pkg.sv
/*
 * Constants, modes, states and the state record of the converter
 * sequencer. Assumes a single 125 MHz bus clock; the converter clock is
 * derived inside the sequencer from the bus clock or from an oscillator
 * level that is sampled on the bus clock.
 */
// What this block does
// - Conversion phase lasts 12.5 converter clock periods after sampling ends.
// - Total time spans 14 to 252 cycles; sampling is 1.5 to 239.5 cycles.
// - End-of-conversion flag rises exactly when the result register loads.
// - Oscillator clock: result ready 1.5 converter cycles plus 2 to 3 bus cycles.
// - Latency is 5 bus cycles at divide-by-2 and 9 at divide-by-4 (4.5 and 8.5 rounded up).
// - Calibration lasts 83 converter cycles; access latency comes on top.
// - With the oscillator, conversion start may slip up to half an oscillator cycle.
package acst_pkg;

    // ------------------------------------------------------------------
    // Converter clock sources
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACST_SRC_OSC = 2'b00,
        ACST_SRC_DIV2 = 2'b01,
        ACST_SRC_DIV4 = 2'b10
    } acst_src_type;

    // ------------------------------------------------------------------
    // Timing, counted in half converter cycles unless noted
    // ------------------------------------------------------------------
    localparam int HALF_W = 9;
    localparam logic [HALF_W-1:0] SAMPLE_HALF_MIN = 9'h003; // 1.5 cycles
    localparam logic [HALF_W-1:0] SAMPLE_HALF_MAX = 9'h1DF; // 239.5 cycles
    localparam logic [HALF_W-1:0] CONV_HALVES = 9'h019; // 12.5 cycles
    localparam logic [HALF_W-1:0] CAL_HALVES = 9'h0A6; // 83 cycles
    localparam logic [HALF_W-1:0] LAT_OSC_HALVES = 9'h003; // 1.5 cycles
    // Bus cycle counts of the result transfer
    localparam logic [3:0] LAT_OSC_BUS = 4'h2;
    localparam logic [3:0] LAT_DIV2_BUS = 4'h5; // 4.5 rounded up
    localparam logic [3:0] LAT_DIV4_BUS = 4'h9; // 8.5 rounded up
    localparam int RESULT_W = 12;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ACST_IDLE = 3'b000,
        ACST_ARMED = 3'b001,
        ACST_SAMPLE = 3'b010,
        ACST_CONVERT = 3'b011,
        ACST_OSC_LAT = 3'b100,
        ACST_BUS_LAT = 3'b101,
        ACST_CAL = 3'b110
    } acst_state_type;

    // ------------------------------------------------------------------
    // Module state, apart from the reset release registers
    // ------------------------------------------------------------------
    typedef struct packed {
        acst_state_type state;
        logic [HALF_W-1:0] half_cnt;
        logic [HALF_W-1:0] sample_len;
        logic [3:0] bus_cnt;
        logic div_cnt;
        logic osc_meta;
        logic osc_sync;
        logic osc_prev;
        logic [RESULT_W-1:0] result;
        logic eoc;
        logic busy;
        logic sampling;
        logic calibrating;
        logic cal_done;
    } acst_regs_type;

    localparam acst_regs_type REGS_RESET = '{
        state: ACST_IDLE,
        half_cnt: 9'h000,
        sample_len: SAMPLE_HALF_MIN,
        bus_cnt: 4'h0,
        div_cnt: 1'b0,
        osc_meta: 1'b0,
        osc_sync: 1'b0,
        osc_prev: 1'b0,
        result: 12'h000,
        eoc: 1'b0,
        busy: 1'b0,
        sampling: 1'b0,
        calibrating: 1'b0,
        cal_done: 1'b0
    };

endpackage : acst_pkg

// file: hw/acst_sequencer.sv
/*
 * Conversion sequencer of a 12-bit successive-approximation converter:
 * sampling, conversion, result transfer with end-of-conversion flag,
 * and calibration. Assumes all inputs synchronous to the bus clock
 * except the reset and the oscillator level, both synchronised here, and a
 * converter code that is stable when the conversion phase ends.
 * The clock source and sampling length must not change while busy;
 * the sampling length is latched at the trigger, the source is not.
 */
`timescale 1ns/1ns
module acst_sequencer (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Configuration
    input wire acst_pkg::acst_src_type clock_source,
    input wire logic [acst_pkg::HALF_W-1:0] sample_halves,
    // Oscillator level and analog code
    input wire logic osc_level,
    input wire logic [acst_pkg::RESULT_W-1:0] analog_code,
    // Requests
    input wire logic trigger,
    input wire logic start_calibration,
    // Result and status
    output logic [acst_pkg::RESULT_W-1:0] conversion_result_register,
    output logic end_of_conversion,
    output logic busy,
    output logic sampling,
    output logic calibrating,
    output logic calibration_done
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_b_reg;

    // Assert at once, release two edges later, so no register leaves
    // reset on an edge that the raw reset pin could race
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_b_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_b_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    acst_pkg::acst_regs_type regs_reg;
    acst_pkg::acst_regs_type regs_next;
    logic half_tick;
    logic [acst_pkg::HALF_W-1:0] len_clamped;
    logic [3:0] lat_bus_len;

    // Half converter cycle strobe for the selected source
    // Oscillator: one strobe per synchronised level change, so both edges
    // count and a skewed duty cycle skews the half cycles with it
    always_comb begin
        case (clock_source)
            acst_pkg::ACST_SRC_OSC:
                half_tick = regs_reg.osc_sync ^ regs_reg.osc_prev;
            acst_pkg::ACST_SRC_DIV2: half_tick = 1'b1;
            acst_pkg::ACST_SRC_DIV4: half_tick = regs_reg.div_cnt;
            default: half_tick = 1'b0;
        endcase
    end

    // Sampling length held to its legal range
    always_comb begin
        if (sample_halves < acst_pkg::SAMPLE_HALF_MIN) begin
            len_clamped = acst_pkg::SAMPLE_HALF_MIN;
        end else if (sample_halves > acst_pkg::SAMPLE_HALF_MAX) begin
            len_clamped = acst_pkg::SAMPLE_HALF_MAX;
        end else begin
            len_clamped = sample_halves;
        end
    end

    // Phase order: idle, armed until the next converter half edge,
    // sampling, conversion, then the result transfer. The oscillator path
    // spends three more half edges before its bus count starts, so its
    // 1.5 converter cycles run on the converter clock itself.
    // The source is read live; a change mid-conversion stretches or
    // shortens the phase in progress, so software must hold it.
    // Next state; pulses drop after one cycle
    always_comb begin
        regs_next = regs_reg;
        regs_next.eoc = 1'b0;
        regs_next.cal_done = 1'b0;
        // Oscillator synchroniser, first stage read only by the second
        regs_next.osc_meta = osc_level;
        regs_next.osc_sync = regs_reg.osc_meta;
        regs_next.osc_prev = regs_reg.osc_sync;
        regs_next.div_cnt = ~regs_reg.div_cnt;
        case (regs_reg.state)
            acst_pkg::ACST_IDLE: begin
                if (start_calibration) begin
                    regs_next.state = acst_pkg::ACST_CAL;
                    regs_next.half_cnt = '0;
                    regs_next.calibrating = 1'b1;
                    regs_next.busy = 1'b1;
                end else if (trigger) begin
                    // Start waits for the next converter edge
                    regs_next.state = acst_pkg::ACST_ARMED;
                    regs_next.sample_len = len_clamped;
                    regs_next.busy = 1'b1;
                end
            end
            acst_pkg::ACST_ARMED: begin
                if (half_tick) begin
                    regs_next.state = acst_pkg::ACST_SAMPLE;
                    regs_next.half_cnt = '0;
                    regs_next.sampling = 1'b1;
                end
            end
            acst_pkg::ACST_SAMPLE: begin
                // Triggers are not looked at here
                if (half_tick) begin
                    if (regs_reg.half_cnt == regs_reg.sample_len - 9'h001) begin
                        regs_next.state = acst_pkg::ACST_CONVERT;
                        regs_next.half_cnt = '0;
                        regs_next.sampling = 1'b0;
                    end else begin
                        regs_next.half_cnt = regs_reg.half_cnt + 9'h001;
                    end
                end
            end
            acst_pkg::ACST_CONVERT: begin
                if (half_tick) begin
                    if (regs_reg.half_cnt == acst_pkg::CONV_HALVES - 9'h001) begin
                        regs_next.half_cnt = '0;
                        if (clock_source == acst_pkg::ACST_SRC_OSC) begin
                            regs_next.state = acst_pkg::ACST_OSC_LAT;
                        end else begin
                            regs_next.state = acst_pkg::ACST_BUS_LAT;
                        end
                        // Loaded here, spent after any oscillator halves
                        regs_next.bus_cnt = lat_bus_len;
                    end else begin
                        regs_next.half_cnt = regs_reg.half_cnt + 9'h001;
                    end
                end
            end
            acst_pkg::ACST_OSC_LAT: begin
                // The 1.5 converter cycles run on the oscillator edges
                if (half_tick) begin
                    if (regs_reg.half_cnt ==
                        acst_pkg::LAT_OSC_HALVES - 9'h001) begin
                        regs_next.state = acst_pkg::ACST_BUS_LAT;
                    end else begin
                        regs_next.half_cnt = regs_reg.half_cnt + 9'h001;
                    end
                end
            end
            acst_pkg::ACST_BUS_LAT: begin
                if (regs_reg.bus_cnt <= 4'h1) begin
                    // Flag and data move together
                    regs_next.result = analog_code;
                    regs_next.eoc = 1'b1;
                    regs_next.busy = 1'b0;
                    regs_next.state = acst_pkg::ACST_IDLE;
                end else begin
                    regs_next.bus_cnt = regs_reg.bus_cnt - 4'h1;
                end
            end
            acst_pkg::ACST_CAL: begin
                // Only converter activity is counted here
                if (half_tick) begin
                    if (regs_reg.half_cnt == acst_pkg::CAL_HALVES - 9'h001) begin
                        regs_next.state = acst_pkg::ACST_IDLE;
                        regs_next.calibrating = 1'b0;
                        regs_next.busy = 1'b0;
                        regs_next.cal_done = 1'b1;
                    end else begin
                        regs_next.half_cnt = regs_reg.half_cnt + 9'h001;
                    end
                end
            end
            default: begin
                regs_next = acst_pkg::REGS_RESET;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            regs_reg <= acst_pkg::REGS_RESET;
        end else begin
            regs_reg <= regs_next;
        end
    end

    // ------------------------------------------------------------------
    // Result transfer latency
    // ------------------------------------------------------------------
    // Bus cycles after the converter phases; 4.5 and 8.5 round up so the
    // flag is never early, at the cost of half a bus cycle
    always_comb begin
        case (clock_source)
            acst_pkg::ACST_SRC_OSC:
                lat_bus_len = acst_pkg::LAT_OSC_BUS;
            acst_pkg::ACST_SRC_DIV2:
                lat_bus_len = acst_pkg::LAT_DIV2_BUS;
            acst_pkg::ACST_SRC_DIV4:
                lat_bus_len = acst_pkg::LAT_DIV4_BUS;
            default: lat_bus_len = acst_pkg::LAT_DIV4_BUS;
        endcase
    end

    // ------------------------------------------------------------------
    // Outputs, straight from the state register
    // ------------------------------------------------------------------
    assign conversion_result_register = regs_reg.result;
    assign end_of_conversion = regs_reg.eoc;
    assign busy = regs_reg.busy;
    assign sampling = regs_reg.sampling;
    assign calibrating = regs_reg.calibrating;
    assign calibration_done = regs_reg.cal_done;

endmodule : acst_sequencer

// file: tb/acst_seq_properties.sv
/*
 * Timing checker of the converter sequencer, bound to its ports.
 * Assumes clock_source and sample_halves are held during a conversion.
 */
`timescale 1ns/1ns
module acst_seq_properties (
    // Clock, reset, configuration
    input wire logic clock,
    input wire logic rst_b,
    input wire acst_pkg::acst_src_type clock_source,
    input wire logic [acst_pkg::HALF_W-1:0] sample_halves,
    // Inputs and outputs watched
    input wire logic osc_level,
    input wire logic [acst_pkg::RESULT_W-1:0] analog_code,
    input wire logic trigger,
    input wire logic start_calibration,
    input wire logic [acst_pkg::RESULT_W-1:0] conversion_result_register,
    input wire logic end_of_conversion,
    input wire logic busy,
    input wire logic sampling,
    input wire logic calibrating,
    input wire logic calibration_done
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic d2;
    logic d4;
    assign d2 = (clock_source == acst_pkg::ACST_SRC_DIV2);
    assign d4 = (clock_source == acst_pkg::ACST_SRC_DIV4);
    property p_eoc_pulse;
        end_of_conversion |=> !end_of_conversion;
    endproperty
    a_eoc_pulse: assert property (p_eoc_pulse) else $error("eoc too long");
    property p_eoc_load;
        end_of_conversion |-> conversion_result_register == $past(analog_code);
    endproperty
    a_eoc_load: assert property (p_eoc_load) else $error("result not loaded");
    property p_hold;
        !end_of_conversion |-> $stable(conversion_result_register);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    property p_idle_at_eoc;
        end_of_conversion |-> !busy && !sampling;
    endproperty
    a_idle_at_eoc: assert property (p_idle_at_eoc) else $error("busy at eoc");
    property p_conv2;
        $fell(sampling) && d2 |-> !end_of_conversion [*8] ##23 end_of_conversion;
    endproperty
    a_conv2: assert property (p_conv2) else $error("div2 conversion span");
    property p_conv4;
        $fell(sampling) && d4 |-> ##[58:61] end_of_conversion;
    endproperty
    a_conv4: assert property (p_conv4) else $error("div4 conversion span");
    property p_sample_min;
        $rose(sampling) && d2 && sample_halves == 9'h003
            |-> sampling [*3] ##1 !sampling;
    endproperty
    a_sample_min: assert property (p_sample_min) else $error("sample span");
    property p_in_busy;
        sampling || calibrating |-> busy;
    endproperty
    a_in_busy: assert property (p_in_busy) else $error("phase without busy");
    property p_no_restart;
        $fell(sampling) && d2 |=> !sampling [*8];
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("restarted");
    property p_cal;
        $rose(calibrating) && d2 |-> ##166
            (calibration_done && !calibrating);
    endproperty
    a_cal: assert property (p_cal) else $error("calibration span");
endmodule : acst_seq_properties

bind acst_sequencer acst_seq_properties u_props (.clock, .rst_b,
    .clock_source, .sample_halves, .osc_level, .analog_code, .trigger,
    .start_calibration, .conversion_result_register, .end_of_conversion,
    .busy, .sampling, .calibrating, .calibration_done);

// file: tb/acst_osc_model.sv
/*
 * Far side: free-running dedicated oscillator and a converter code that
 * changes every bus cycle. Assumes the bus clock of the bench.
 */
`timescale 1ns/1ns
module acst_osc_model #(
    parameter int HALF_NS = 36
) (
    // Bus clock
    input wire logic clock,
    // Oscillator and code
    output logic osc_level,
    output logic [acst_pkg::RESULT_W-1:0] analog_code
);
    // Oscillator runs free; the offset keeps its edges off the bus edges
    initial begin
        osc_level = 1'b0;
        #2;
        forever #(HALF_NS) osc_level = ~osc_level;
    end
    // Code moves every cycle so a late or early capture shows
    initial analog_code = 12'hA5C;
    always @(negedge clock) analog_code <= analog_code + 12'h3A7;
endmodule : acst_osc_model

// file: tb/tb_adc_conversion_sequencer_timing.sv
/*
 * Self-checking bench of the converter sequencer.
 * Assumes the oscillator model and the bound checker.
 */
`timescale 1ns/1ns
module tb_adc_conversion_sequencer_timing;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    acst_pkg::acst_src_type clock_source = acst_pkg::ACST_SRC_DIV2;
    logic [8:0] sample_halves = 9'h003;
    logic trigger = 1'b0;
    logic start_calibration = 1'b0;
    logic osc_level;
    logic [11:0] analog_code;
    logic [11:0] result;
    logic eoc, busy, sampling, calibrating, cal_done;
    int n_mismatch = 0;
    int num_checks = 0;
    int n;
    always #4 clock = ~clock;
    acst_osc_model u_osc (.clock(clock), .osc_level(osc_level),
        .analog_code(analog_code));
    acst_sequencer dut (.clock(clock), .rst_b(rst_b),
        .clock_source(clock_source), .sample_halves(sample_halves),
        .osc_level(osc_level), .analog_code(analog_code), .trigger(trigger),
        .start_calibration(start_calibration),
        .conversion_result_register(result), .end_of_conversion(eoc),
        .busy(busy), .sampling(sampling), .calibrating(calibrating),
        .calibration_done(cal_done));
    // ----------------------------------------------------------------
    // Compare and closing tasks
    // ----------------------------------------------------------------
    task automatic check_val(input string what, input logic [11:0] exp,
        input logic [11:0] seen);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : check_val
    task automatic check_span(input string what, input int lo, input int hi,
        input int seen);
        num_checks++;
        if (seen < lo || seen > hi) begin
            n_mismatch++;
            $display("wrong value %s exp %0d..%0d seen %0d", what, lo, hi, seen);
        end
    endtask : check_span
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // One conversion; hold keeps both requests up to prove they are ignored
    task automatic conv(input acst_pkg::acst_src_type src, input logic [8:0] s,
        input logic hold, output int cnt);
        @(negedge clock);
        clock_source = src;
        sample_halves = s;
        trigger = 1'b1;
        @(negedge clock);
        trigger = hold;
        start_calibration = hold;
        cnt = 0;
        while (cnt < 2000 && eoc !== 1'b1) begin
            @(posedge clock);
            #1;
            cnt++;
        end
        check_val("result", analog_code, result);
        @(negedge clock);
        trigger = 1'b0;
        start_calibration = 1'b0;
    endtask : conv
    // Sampling bounds and clamping at divide-by-2, with refused requests
    task automatic t_div2_table;
        logic [8:0] s_tab [4] = '{9'h000, 9'h003, 9'h1DF, 9'h1FF};
        int exp_tab [4] = '{34, 34, 510, 510};
        for (int i = 0; i < 4; i++) begin
            conv(acst_pkg::ACST_SRC_DIV2, s_tab[i], i == 1, n);
            check_span("div2 span", exp_tab[i], exp_tab[i], n);
        end
    endtask : t_div2_table
    task automatic t_div4;
        conv(acst_pkg::ACST_SRC_DIV4, 9'h003, 1'b0, n);
        check_span("div4 span", 66, 67, n);
    endtask : t_div4
    // Oscillator half period 4.5 cycles; start may slip half an oscillator cycle
    task automatic t_osc;
        for (int i = 0; i < 3; i++) begin
            conv(acst_pkg::ACST_SRC_OSC, 9'h003, 1'b0, n);
            check_span("osc span", 142, 147, n);
        end
    endtask : t_osc
    // Calibration wins over a simultaneous trigger and makes no result
    task automatic t_cal;
        int seen_eoc;
        seen_eoc = 0;
        @(negedge clock);
        clock_source = acst_pkg::ACST_SRC_DIV2;
        start_calibration = 1'b1;
        trigger = 1'b1;
        @(negedge clock);
        start_calibration = 1'b0;
        trigger = 1'b0;
        n = 0;
        while (n < 2000 && cal_done !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (eoc === 1'b1) seen_eoc++;
        end
        check_span("cal span", 166, 166, n);
        check_span("eoc in cal", 0, 0, seen_eoc);
    endtask : t_cal
    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        t_div2_table();
        t_div4();
        t_osc();
        t_cal();
        tally_and_finish();
    end
    // Whole run is about 2000 cycles; allow 25000 cycles, over twelve times that
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb_adc_conversion_sequencer_timing
